// [core/cbft_pkg.sv]
// shared constants and types of the breaker failure timer
package cbft_pkg;
  localparam int CLK_HZ      = 40_000_000;
  localparam int TICK_MS     = 5;
  localparam int MS_PER_S    = 1000;
  localparam int TICK_CYC_DEF = CLK_HZ / MS_PER_S * TICK_MS;
  localparam int MS_CYC_DEF   = CLK_HZ / MS_PER_S;
  localparam int RETRIP_DEF_MS = 100;
  localparam int CBF_DEF_MS    = 200;
  localparam int DLY_W = 20;
  localparam logic [DLY_W-1:0] RTD_RST = DLY_W'(RETRIP_DEF_MS / TICK_MS);
  localparam logic [DLY_W-1:0] CBD_RST = DLY_W'(CBF_DEF_MS / TICK_MS);
  localparam int N_IN   = 5;
  localparam int N_EV   = 8;
  localparam int N_CNT  = 4;
  localparam int N_REC  = 12;
  localparam logic [3:0] REC_LAST = 4'hb;
  // event sources
  localparam int EV_START  = 0;
  localparam int EV_RETRIP = 1;
  localparam int EV_CBF    = 2;
  localparam int EV_BLOCK  = 3;
  localparam int EV_DOMON  = 4;
  localparam int EV_SIGNAL = 5;
  localparam int EV_PHASE  = 6;
  localparam int EV_RES    = 7;
  // synchronised input bit positions
  localparam int IN_PH  = 0;
  localparam int IN_RS  = 1;
  localparam int IN_DO  = 2;
  localparam int IN_SIG = 3;
  localparam int IN_BLK = 4;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_RTD   = 8'h04;
  localparam logic [7:0] OFF_CBD   = 8'h08;
  localparam logic [7:0] OFF_STAT  = 8'h0c;
  localparam logic [7:0] OFF_IST   = 8'h10;
  localparam logic [7:0] OFF_IMSK  = 8'h14;
  localparam logic [7:0] OFF_CNT0  = 8'h18;
  localparam logic [7:0] OFF_RSEL  = 8'h28;
  localparam logic [7:0] OFF_RPTR  = 8'h2c;
  localparam logic [7:0] OFF_RTIME = 8'h30;
  localparam logic [7:0] OFF_RINFO = 8'h34;
  localparam logic [7:0] OFF_RCUR  = 8'h38;
  localparam logic [7:0] OFF_RTTR  = 8'h3c;
  localparam logic [7:0] OFF_RTTC  = 8'h40;
  localparam logic [7:0] OFF_NOW   = 8'h44;
  // control fields
  localparam int CTRL_RT_EN  = 2;
  localparam int CTRL_EV_ON  = 3;
  localparam int CTRL_EV_OFF = 4;
  localparam int CTRL_GRP    = 5;
  localparam int CTRL_CLR    = 8;
  localparam int INFO_GRP    = 8;
  localparam logic [7:0] CTRL_RST = 8'h1c;
  typedef enum logic [1:0] {
    MODE_CUR, MODE_CUR_AND_DO, MODE_CUR_OR_DO, MODE_SIGNAL
  } cbft_mode_t;
endpackage : cbft_pkg

// [core/cbft_sync.sv]
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module cbft_sync
  import cbft_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic [N_IN-1:0] d,
  output logic      [N_IN-1:0] q
);
  logic [N_IN-1:0] s1_q;
  logic [N_IN-1:0] s2_q;
  logic [N_IN-1:0] s3_q;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      q    <= '0;
    end
    else
    begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // follow only where stages two and three agree
      q    <= (s2_q & s3_q) | (q & (s2_q ^ s3_q));
    end
  end
endmodule : cbft_sync

// [core/cbft_core.sv]
// breaker failure supervision timers, events, records, wishbone slave
`timescale 1ns/1ps
module cbft_core
  import cbft_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC_DEF,
  parameter int MS_CYCLES   = MS_CYC_DEF
)
(
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  input  wire logic        CYC_I,
  input  wire logic        STB_I,
  input  wire logic        WE_I,
  input  wire logic [7:0]  ADR_I,
  input  wire logic [3:0]  SEL_I,
  input  wire logic [31:0] DAT_I,
  output logic      [31:0] DAT_O,
  output logic             ACK_O,
  input  wire logic        PHASE_PICKUP,
  input  wire logic        RESIDUAL_PICKUP,
  input  wire logic        TRIP_CONTACT,
  input  wire logic        DIGITAL_TRIP_IN,
  input  wire logic        BLOCK_IN,
  input  wire logic [15:0] PHASE_MAX_CUR,
  input  wire logic [15:0] RESIDUAL_CUR,
  output logic             RETRIP_OUTPUT,
  output logic             BREAKER_FAILURE_OUTPUT,
  output logic             START_OUTPUT,
  output logic             BLOCKED_OUTPUT,
  output logic             IRQ,
  output logic [7:0]       EVT_ON,
  output logic [7:0]       EVT_OFF,
  output logic [31:0]      EVT_TIME
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);

  function automatic logic [31:0] wmask(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[i*8 +: 8] = dat[i*8 +: 8];
    return r;
  endfunction : wmask

  function automatic logic [DLY_W-1:0] sat_inc(input logic [DLY_W-1:0] c);
    return (&c) ? c : c + 1'b1;
  endfunction : sat_inc

  function automatic logic [DLY_W-1:0] remain(input logic [DLY_W-1:0] dly,
                                              input logic [DLY_W-1:0] c);
    return (c >= dly) ? '0 : dly - c;
  endfunction : remain

  function automatic logic [2:0] first_set(input logic [N_EV-1:0] v);
    logic [2:0] r;
    r = '0;
    for (int i = N_EV - 1; i >= 0; i--)
      if (v[i])
        r = 3'(i);
    return r;
  endfunction : first_set

  logic [N_IN-1:0]  in_s;
  logic             hit, wr, cnt_clr, tick, cur, cond, blk;
  logic [31:0]      tick_cnt_q, ms_div_q, ms_q;
  logic [7:0]       ctrl_q;
  logic [DLY_W-1:0] rtd_q, cbd_q, rt_cnt_q, cb_cnt_q, rt_next, cb_next;
  logic             start_q, retrip_q, cbf_q, blocked_q, ack_q;
  logic [N_EV-1:0]  st_now, st_prev_q, ev_on, ev_off;
  logic [N_CNT-1:0] irq_st_q, irq_msk_q;
  logic [31:0]      cnt_q [N_CNT];
  logic [3:0]       rec_sel_q, rec_wp_q, rec_num_q, rs_idx;
  logic [31:0]      rec_time [N_REC];
  logic [2:0]       rec_evt  [N_REC];
  logic [2:0]       rec_grp  [N_REC];
  logic [31:0]      rec_cur  [N_REC];
  logic [DLY_W-1:0] rec_ttr  [N_REC];
  logic [DLY_W-1:0] rec_ttc  [N_REC];
  logic [31:0]      rd_d, dat_q;
  logic [7:0]       evt_on_q, evt_off_q;
  logic [31:0]      evt_time_q;
  cbft_mode_t       mode;

  cbft_sync u_sync (
    .clk (REF_CLK),
    .rst (SYS_RST),
    .d   ({BLOCK_IN, DIGITAL_TRIP_IN, TRIP_CONTACT, RESIDUAL_PICKUP,
           PHASE_PICKUP}),
    .q   (in_s)
  );

  assign mode    = cbft_mode_t'(ctrl_q[1:0]);
  assign hit     = CYC_I & STB_I & ~ack_q;
  assign wr      = hit & WE_I;
  assign cnt_clr = wr && ADR_I == OFF_CTRL && SEL_I[1] && DAT_I[CTRL_CLR];
  assign tick    = tick_cnt_q == 32'(TICK_CYCLES - 1);
  assign cur     = in_s[IN_PH] | in_s[IN_RS];
  assign blk     = in_s[IN_BLK];
  assign rt_next = sat_inc(rt_cnt_q);
  assign cb_next = sat_inc(cb_cnt_q);

  // starting condition per criterion
  always_comb
  begin
    unique case (mode)
      MODE_CUR:        cond = cur;
      // current waits for the energized contact
      MODE_CUR_AND_DO: cond = cur & in_s[IN_DO];
      MODE_CUR_OR_DO:  cond = cur | in_s[IN_DO];
      MODE_SIGNAL:     cond = in_s[IN_SIG];
    endcase
  end

  // processing tick and millisecond time base
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      tick_cnt_q <= '0;
      ms_div_q   <= '0;
      ms_q       <= '0;
    end
    else
    begin
      tick_cnt_q <= tick ? '0 : tick_cnt_q + 1'b1;
      if (ms_div_q == 32'(MS_CYCLES - 1))
      begin
        ms_div_q <= '0;
        ms_q     <= ms_q + 1'b1;
      end
      else
        ms_div_q <= ms_div_q + 1'b1;
    end
  end

  // delay timers and outputs, evaluated once per tick
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      rt_cnt_q  <= '0;
      cb_cnt_q  <= '0;
      start_q   <= 1'b0;
      retrip_q  <= 1'b0;
      cbf_q     <= 1'b0;
      blocked_q <= 1'b0;
    end
    else
    begin
      if (tick)
      begin
        // blocked pick-up skips timing and releases start
        blocked_q <= cond & blk;
        if (!cond || blk)
        begin
          // timers cleared on the mode's release
          rt_cnt_q <= '0;
          cb_cnt_q <= '0;
          start_q  <= 1'b0;
          retrip_q <= 1'b0;
          cbf_q    <= 1'b0;
        end
        else
        begin
          // one step per tick, delays in 5 ms steps
          rt_cnt_q <= rt_next;
          cb_cnt_q <= cb_next;
          start_q  <= 1'b1;
          retrip_q <= ctrl_q[CTRL_RT_EN] && mode != MODE_SIGNAL &&
                      rt_next >= rtd_q;
          cbf_q    <= cb_next >= cbd_q;
        end
      end
      // disabled retrip never drives the output
      if (!ctrl_q[CTRL_RT_EN])
        retrip_q <= 1'b0;
    end
  end

  // state edges become ON and OFF events
  assign st_now = {in_s[IN_RS], in_s[IN_PH], in_s[IN_SIG], in_s[IN_DO],
                   blocked_q, cbf_q, retrip_q, start_q};
  assign ev_on  = st_now & ~st_prev_q;
  assign ev_off = ~st_now & st_prev_q;

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      st_prev_q  <= '0;
      evt_on_q   <= '0;
      evt_off_q  <= '0;
      evt_time_q <= '0;
    end
    else
    begin
      st_prev_q <= st_now;
      // output kinds chosen by the enables; records take one entry per cycle with any ON edge (lowest source), counters only those of the first four sources
      evt_on_q  <= ev_on & {N_EV{ctrl_q[CTRL_EV_ON]}};
      evt_off_q <= ev_off & {N_EV{ctrl_q[CTRL_EV_OFF]}};
      if (|(ev_on | ev_off))
        evt_time_q <= ms_q;
    end
  end

  // event counters, a clear still counts a coincident event as one
  always_ff @(posedge REF_CLK)
  begin
    for (int i = 0; i < N_CNT; i++)
    begin
      if (SYS_RST)
        cnt_q[i] <= '0;
      else if (cnt_clr)
        cnt_q[i] <= {31'h0, ev_on[i]};
      else if (ev_on[i])
        cnt_q[i] <= cnt_q[i] + 1'b1;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      rec_wp_q  <= '0;
      rec_num_q <= '0;
    end
    else if (|ev_on)
    begin
      rec_wp_q <= (rec_wp_q == REC_LAST) ? '0 : rec_wp_q + 1'b1;
      if (rec_num_q != 4'(N_REC))
        rec_num_q <= rec_num_q + 1'b1;
    end
  end

  // record content; data only, so no reset
  always_ff @(posedge REF_CLK)
  begin
    if (|ev_on)
    begin
      rec_time[rec_wp_q] <= ms_q;
      rec_evt[rec_wp_q]  <= first_set(ev_on);
      rec_grp[rec_wp_q]  <= ctrl_q[CTRL_GRP +: 3];
      rec_cur[rec_wp_q]  <= {RESIDUAL_CUR, PHASE_MAX_CUR};
      rec_ttr[rec_wp_q]  <= remain(rtd_q, rt_cnt_q);
      rec_ttc[rec_wp_q]  <= remain(cbd_q, cb_cnt_q);
    end
  end

  // control registers and interrupt status; set wins over clear
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      ctrl_q    <= CTRL_RST;
      rtd_q     <= RTD_RST;
      cbd_q     <= CBD_RST;
      irq_msk_q <= '0;
      irq_st_q  <= '0;
      rec_sel_q <= '0;
    end
    else
    begin
      if (wr && ADR_I == OFF_CTRL)
        ctrl_q <= 8'(wmask({24'h0, ctrl_q}, DAT_I, SEL_I));
      if (wr && ADR_I == OFF_RTD)
        rtd_q <= DLY_W'(wmask({12'h0, rtd_q}, DAT_I, SEL_I));
      if (wr && ADR_I == OFF_CBD)
        cbd_q <= DLY_W'(wmask({12'h0, cbd_q}, DAT_I, SEL_I));
      if (wr && ADR_I == OFF_IMSK && SEL_I[0])
        irq_msk_q <= DAT_I[N_CNT-1:0];
      if (wr && ADR_I == OFF_RSEL && SEL_I[0])
        rec_sel_q <= DAT_I[3:0];
      if (wr && ADR_I == OFF_IST && SEL_I[0])
        irq_st_q <= (irq_st_q & ~DAT_I[N_CNT-1:0]) | ev_on[N_CNT-1:0];
      else
        irq_st_q <= irq_st_q | ev_on[N_CNT-1:0];
    end
  end

  // out-of-range record index reads entry zero rather than garbage
  assign rs_idx = (rec_sel_q < 4'(N_REC)) ? rec_sel_q : '0;

  always_comb
  begin
    rd_d = '0;
    case (ADR_I)
      OFF_CTRL:  rd_d = {24'h0, ctrl_q};
      OFF_RTD:   rd_d = {12'h0, rtd_q};
      OFF_CBD:   rd_d = {12'h0, cbd_q};
      OFF_STAT:  rd_d = {23'h0, in_s, blocked_q, cbf_q, retrip_q, start_q};
      OFF_IST:   rd_d = {28'h0, irq_st_q};
      OFF_IMSK:  rd_d = {28'h0, irq_msk_q};
      OFF_CNT0:  rd_d = cnt_q[EV_START];
      8'h1c:     rd_d = cnt_q[EV_RETRIP];
      8'h20:     rd_d = cnt_q[EV_CBF];
      8'h24:     rd_d = cnt_q[EV_BLOCK];
      OFF_RSEL:  rd_d = {28'h0, rec_sel_q};
      OFF_RPTR:  rd_d = {20'h0, rec_num_q, 4'h0, rec_wp_q};
      OFF_RTIME: rd_d = rec_time[rs_idx];
      OFF_RINFO: rd_d = {21'h0, rec_grp[rs_idx], 5'h0, rec_evt[rs_idx]};
      OFF_RCUR:  rd_d = rec_cur[rs_idx];
      OFF_RTTR:  rd_d = {12'h0, rec_ttr[rs_idx]};
      OFF_RTTC:  rd_d = {12'h0, rec_ttc[rs_idx]};
      OFF_NOW:   rd_d = ms_q;
      default:   rd_d = '0;
    endcase
  end

  // single-wait-state slave: ack one cycle after request
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end
    else
    begin
      ack_q <= hit;
      if (hit && !WE_I)
        dat_q <= rd_d;
    end
  end

  assign ACK_O                  = ack_q;
  assign DAT_O                  = dat_q;
  assign RETRIP_OUTPUT          = retrip_q;
  assign BREAKER_FAILURE_OUTPUT = cbf_q;
  assign START_OUTPUT           = start_q;
  assign BLOCKED_OUTPUT         = blocked_q;
  assign IRQ                    = |(irq_st_q & irq_msk_q);
  assign EVT_ON                 = evt_on_q;
  assign EVT_OFF                = evt_off_q;
  assign EVT_TIME               = evt_time_q;

  a_cur_start: assert property (
    tick && mode == MODE_CUR && cur && !blk |=> start_q && rt_cnt_q != 0)
    else $error("current pick-up did not start timers");
  a_retrip_fire: assert property (
    tick && cond && !blk && ctrl_q[CTRL_RT_EN] && mode != MODE_SIGNAL &&
    rt_next >= rtd_q |=> retrip_q)
    else $error("retrip not raised at delay");
  a_cbf_fire: assert property (
    tick && cond && !blk && cb_next >= cbd_q |=> cbf_q)
    else $error("breaker failure not raised at delay");
  a_cbf_early: assert property (
    tick && cond && !blk && cb_next < cbd_q |=> !cbf_q)
    else $error("breaker failure raised early");
  a_cur_clear: assert property (
    tick && mode == MODE_CUR && !cur |=> rt_cnt_q == 0 && cb_cnt_q == 0)
    else $error("timers not cleared on current drop");
  a_and_hold: assert property (
    tick && mode == MODE_CUR_AND_DO && cur && !in_s[IN_DO]
    |=> !start_q && cb_cnt_q == 0)
    else $error("timers ran without trip contact");
  a_and_clear: assert property (
    tick && mode == MODE_CUR_AND_DO && !(cur && in_s[IN_DO])
    |=> !cbf_q && !retrip_q && rt_cnt_q == 0)
    else $error("and-mode clear failed");
  a_or_start: assert property (
    tick && mode == MODE_CUR_OR_DO && in_s[IN_DO] && !blk |=> start_q)
    else $error("contact did not start or-mode");
  a_or_clear: assert property (
    tick && mode == MODE_CUR_OR_DO && !cur && !in_s[IN_DO]
    |=> cb_cnt_q == 0 && !cbf_q)
    else $error("or-mode clear failed");
  a_sig_mode: assert property (
    tick && mode == MODE_SIGNAL && in_s[IN_SIG] && !blk
    |=> start_q && !retrip_q)
    else $error("digital-input mode misbehaved");
  a_block_skip: assert property (
    tick && blk |=> !start_q && cb_cnt_q == 0 && blocked_q == $past(cond))
    else $error("blocking did not stop timing");
  a_retrip_off: assert property (
    !ctrl_q[CTRL_RT_EN] |=> !retrip_q)
    else $error("retrip active while disabled");
  a_evt_on: assert property (
    ev_on[EV_CBF] && ctrl_q[CTRL_EV_ON] |=> EVT_ON[EV_CBF] &&
    EVT_TIME == $past(ms_q))
    else $error("failure ON event not emitted");
  a_cnt_step: assert property (
    ev_on[EV_RETRIP] && !cnt_clr |=>
    cnt_q[EV_RETRIP] == $past(cnt_q[EV_RETRIP]) + 32'h1)
    else $error("retrip counter did not step");
  a_rec_wrap: assert property (
    (|ev_on) && rec_wp_q == REC_LAST |=> rec_wp_q == 4'h0)
    else $error("record pointer did not wrap");
  a_rec_time: assert property (
    (|ev_on) |=> rec_time[$past(rec_wp_q)] == $past(ms_q))
    else $error("record time not captured");
endmodule : cbft_core

// [verification/cbft_plant.sv]
// model of breaker coils and primary protection stage
`timescale 1ns/1ps
module cbft_plant
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ph_fault,
  input  wire logic rs_fault,
  input  wire logic prim_trip,
  input  wire logic sig_trip,
  input  wire logic blk_cmd,
  input  wire logic retrip_ok,
  input  wire logic retrip,
  input  wire logic failure,
  output logic      ph_pick,
  output logic      rs_pick,
  output logic      contact,
  output logic      dig_in,
  output logic      blk_in
);
  logic open_q;
  // fault current flows until a coil opens a breaker
  always_ff @(posedge clk)
  begin
    if (rst || !(ph_fault || rs_fault))
      open_q <= 1'b0;
    else if (failure || (retrip && retrip_ok))
      open_q <= 1'b1;
  end
  // backup coil may fail, so retrip only clears when retrip_ok
  assign ph_pick = ph_fault && !open_q;
  assign rs_pick = rs_fault && !open_q;
  assign contact = prim_trip;
  assign dig_in  = sig_trip;
  assign blk_in  = blk_cmd;
endmodule : cbft_plant

// [verification/testbench.sv]
// self-checking bench of the breaker failure timer
`timescale 1ns/1ps
module testbench;
  import cbft_pkg::*;
  localparam int T = 8;
  localparam int MSC = 4;
  int          ms_n = 0;
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic        cyc  = 1'b0;
  logic        we   = 1'b0;
  logic [7:0]  adr  = 8'h00;
  logic [3:0]  sel  = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [15:0] pcur = 16'h0;
  logic [15:0] rcur = 16'h0;
  logic        phf = 0, rsf = 0, prt = 0, sgt = 0, blk = 0, rok = 0;
  logic        ph, rs, tc, di, bk, rt, bf, st, bo, irq, ack;
  logic [31:0] rdat, rv, etime, v;
  logic [31:0] s = 32'hfd67;
  logic [7:0]  eon, eoff;
  logic [7:0]  seen_on  = 8'h00;
  logic [7:0]  seen_off = 8'h00;
  logic [3:0]  outs;
  int          mismatches = 0, compares = 0, n, rtd, cbd;
  int          rt_cnt = 0, eon_cnt = 0, k0, k1;
  assign outs = {bo, st, bf, rt};
  initial
  begin
    forever #12.5 clk = ~clk;
  end
  cbft_core #(.TICK_CYCLES(T), .MS_CYCLES(MSC)) u_cbft_core (
    .REF_CLK(clk), .SYS_RST(rst), .CYC_I(cyc), .STB_I(cyc), .WE_I(we),
    .ADR_I(adr), .SEL_I(sel), .DAT_I(wdat), .DAT_O(rdat), .ACK_O(ack),
    .PHASE_PICKUP(ph), .RESIDUAL_PICKUP(rs), .TRIP_CONTACT(tc),
    .DIGITAL_TRIP_IN(di), .BLOCK_IN(bk), .PHASE_MAX_CUR(pcur),
    .RESIDUAL_CUR(rcur), .RETRIP_OUTPUT(rt), .BREAKER_FAILURE_OUTPUT(bf),
    .START_OUTPUT(st), .BLOCKED_OUTPUT(bo), .IRQ(irq), .EVT_ON(eon),
    .EVT_OFF(eoff), .EVT_TIME(etime));
  cbft_plant u_cbft_plant (
    .clk(clk), .rst(rst), .ph_fault(phf), .rs_fault(rsf),
    .prim_trip(prt), .sig_trip(sgt), .blk_cmd(blk), .retrip_ok(rok),
    .retrip(rt), .failure(bf), .ph_pick(ph), .rs_pick(rs),
    .contact(tc), .dig_in(di), .blk_in(bk));
  // edges seen out of reset, our own millisecond reference
  always @(posedge clk)
  begin
    if (!rst) ms_n++;
  end
  always @(negedge clk)
  begin
    seen_on  = seen_on | eon;
    seen_off = seen_off | eoff;
    if ((eon | eoff) !== 8'h00)
      chk("event time", 32'((ms_n - 1) / MSC), etime);
    if (rt === 1'b1) rt_cnt++;
    if (eon !== 8'h00) eon_cnt++;
  end
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : rnd
  function automatic logic [31:0] ctl(input int md, input logic rten);
    return 32'h18 | (32'(rten) << 2) | 32'(md);
  endfunction : ctl
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [3:0] m, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= m;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    rv = rdat;
    cyc <= 1'b0;
    we  <= 1'b0;
    chk("bus ack", 32'h1, {31'h0, ack});
  endtask : wb
  task automatic rd(input logic [7:0] a);
    wb(1'b0, a, 4'hf, 32'h0);
  endtask : rd
  task automatic setup(input int md, input logic rten);
    wb(1'b1, OFF_CTRL, 4'hf, ctl(md, rten));
    wb(1'b1, OFF_RTD, 4'hf, 32'(rtd));
    wb(1'b1, OFF_CBD, 4'hf, 32'(cbd));
    @(posedge clk);
  endtask : setup
  // counts falling edges until the output reaches the level
  task automatic wait_out(input int b, input logic val, input int lim);
    n = 0;
    while (outs[b] !== val && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    chk("output level", {31'h0, val}, {31'h0, outs[b]});
  endtask : wait_out
  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  initial
  begin
    repeat (40000) @(posedge clk);
    mismatches++;
    stop_test();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(OFF_CTRL);
    chk("ctrl reset", 32'h1c, rv);
    rd(OFF_RTD);
    chk("rtd reset", 32'(RTD_RST), rv);
    rd(OFF_CBD);
    chk("cbd reset", 32'(CBD_RST), rv);
    wb(1'b1, 8'hfc, 4'hf, 32'hffff_ffff);
    rd(8'hfc);
    chk("unmapped", 32'h0, rv);
    wb(1'b1, OFF_IMSK, 4'h1, 32'h4);
    for (int i = 0; i < 3; i++)
    begin
      v = rnd();
      rtd = 2 + int'(v[1:0]);
      cbd = rtd + 2 + int'(v[3:2]);
      setup(0, 1'b1);
      rok  <= (i == 2);
      pcur <= v[31:16];
      rcur <= v[15:0];
      phf  <= v[4] || i == 1;
      rsf  <= !v[4] || i == 2;
      @(negedge clk);
      wait_out(2, 1'b1, 3 * T);
      wait_out(0, 1'b1, rtd * T);
      chk("retrip time", 32'((rtd - 1) * T), 32'(n));
      if (i < 2)
      begin
        wait_out(1, 1'b1, cbd * T);
        chk("failure time", 32'((cbd - rtd) * T), 32'(n));
      end
      @(negedge clk);
      if (i == 0) chk("irq", 32'h1, {31'h0, irq});
      wait_out(2, 1'b0, 3 * T);
      chk("all clear", 32'h0, {28'h0, outs});
      if (i == 0)
      begin
        wb(1'b1, OFF_RSEL, 4'h1, 32'h0);
        rd(OFF_RINFO);
        chk("rec event", v[4] ? 32'h6 : 32'h7, rv & 32'h707);
        rd(OFF_RCUR);
        chk("rec cur", {v[15:0], v[31:16]}, rv);
      end
      @(posedge clk);
      phf <= 1'b0;
      rsf <= 1'b0;
    end
    rd(OFF_CNT0);
    chk("start count", 32'h3, rv);
    rd(OFF_CNT0 + 8'h4);
    chk("retrip count", 32'h3, rv);
    rd(OFF_CNT0 + 8'h8);
    chk("fail count", 32'h2, rv);
    wb(1'b1, OFF_IST, 4'h1, 32'hf);
    chk("irq clear", 32'h0, {31'h0, irq});
    rtd = 2;
    cbd = 4;
    setup(1, 1'b1);
    phf <= 1'b1;
    rok <= 1'b0;
    repeat (6 * T) @(negedge clk);
    chk("and held", 32'h0, {28'h0, outs});
    @(posedge clk);
    prt <= 1'b1;
    @(negedge clk);
    wait_out(2, 1'b1, 3 * T);
    @(posedge clk);
    prt <= 1'b0;
    wait_out(2, 1'b0, 3 * T);
    @(posedge clk);
    prt <= 1'b1;
    wait_out(1, 1'b1, 6 * T);
    wait_out(1, 1'b0, 3 * T);
    @(posedge clk);
    phf <= 1'b0;
    setup(2, 1'b1);
    prt <= 1'b1;
    wait_out(1, 1'b1, 7 * T);
    repeat (3 * T) @(negedge clk);
    chk("or held", 32'h1, {31'h0, bf});
    @(posedge clk);
    prt <= 1'b0;
    wait_out(1, 1'b0, 3 * T);
    setup(3, 1'b1);
    k0 = rt_cnt;
    sgt <= 1'b1;
    wait_out(1, 1'b1, 7 * T);
    chk("sig retrip", 32'(k0), 32'(rt_cnt));
    @(posedge clk);
    sgt <= 1'b0;
    wait_out(1, 1'b0, 3 * T);
    setup(0, 1'b1);
    phf <= 1'b1;
    wait_out(2, 1'b1, 3 * T);
    @(posedge clk);
    blk <= 1'b1;
    wait_out(3, 1'b1, 3 * T);
    chk("start released", 32'h0, {31'h0, st});
    @(posedge clk);
    phf <= 1'b0;
    blk <= 1'b0;
    wait_out(3, 1'b0, 3 * T);
    rd(OFF_CNT0 + 8'hc);
    chk("block count", 32'h1, rv);
    repeat (4) @(negedge clk);
    chk("on events", 32'hff, {24'h0, seen_on});
    chk("off events", 32'hff, {24'h0, seen_off});
    wb(1'b1, OFF_CTRL, 4'hf, 32'h10);
    k0 = rt_cnt;
    k1 = eon_cnt;
    phf <= 1'b1;
    wait_out(1, 1'b1, 6 * T);
    wait_out(1, 1'b0, 3 * T);
    chk("retrip off", 32'(k0), 32'(rt_cnt));
    chk("on gated", 32'(k1), 32'(eon_cnt));
    @(posedge clk);
    phf <= 1'b0;
    rd(OFF_RPTR);
    chk("rec count", 32'hc, 32'(rv[11:8]));
    wb(1'b1, OFF_CTRL, 4'h2, 32'h100);
    rd(OFF_CNT0);
    chk("count clear", 32'h0, rv);
    stop_test();
  end
endmodule : testbench
